// ### pcg_pkg.sv
package pcg_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int N_PCK  = 4;

    // register byte offsets
    localparam logic [7:0] OFF_OSC  = 8'h20;
    localparam logic [7:0] OFF_MCFR = 8'h24;
    localparam logic [7:0] OFF_PLL  = 8'h2C;
    localparam logic [7:0] OFF_MCK  = 8'h30;
    localparam logic [7:0] OFF_PCK0 = 8'h40;
    localparam logic [7:0] OFF_IER  = 8'h60;
    localparam logic [7:0] OFF_IDR  = 8'h64;
    localparam logic [7:0] OFF_SR   = 8'h68;
    localparam logic [7:0] OFF_IMR  = 8'h6C;
    localparam logic [7:0] OFF_STEP = 8'h04;

    // shared status / interrupt bit layout
    localparam int ST_OSC   = 0;
    localparam int ST_LOCK  = 2;
    localparam int ST_MCK   = 3;
    localparam int ST_PCK0  = 8;
    localparam int MEAS_RDY = 16;

    // writable bits and reset values
    localparam logic [31:0] IRQ_BITS  = 32'h0000_0F0D;
    localparam logic [31:0] PLL_WMASK = 32'h37FF_FFFF;
    localparam logic [31:0] CLK_WMASK = 32'h0000_001F;
    localparam logic [31:0] OSC_WMASK = 32'h0000_FF03;
    localparam logic [31:0] REG_RST   = 32'h0000_0000;

    // timing figures: window end in slow clock periods, oscillator count scale as a shift (times eight)
    localparam logic [4:0] MEAS_LAST = 5'h0F;
    localparam int         OSC_SHIFT = 3;

    // field encodings
    localparam logic [2:0] CLOCK_PRESCALER_RSVD = 3'h7;
    localparam logic [1:0] USB_DIV1  = 2'h0;
    localparam logic [1:0] USB_DIV2  = 2'h1;
    localparam logic [1:0] USB_DIV4  = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLV  = 2'h2;

    typedef enum logic [1:0] {
        CSS_SLOW = 2'h0,
        CSS_MAIN = 2'h1,
        CSS_RSVD = 2'h2,
        CSS_PLL  = 2'h3
    } pcg_css_t;

    typedef enum logic [2:0] {
        MS_OFF   = 3'h1,
        MS_COUNT = 3'h2,
        MS_DONE  = 3'h4
    } pcg_meas_t;

    typedef struct packed {
        logic [1:0]  rsv2;
        logic [1:0]  usb_clock_divider;
        logic        rsv1;
        logic [10:0] mul;
        logic [1:0]  range;
        logic [5:0]  lock_delay;
        logic [7:0]  div;
    } pcg_pll_t;

    typedef struct packed {
        logic [26:0] rsv;
        logic [2:0]  clock_prescaler;
        pcg_css_t    css;
    } pcg_clk_t;

    typedef struct packed {
        logic [15:0] rsv2;
        logic [7:0]  count;
        logic [5:0]  rsv1;
        logic        bypass;
        logic        enable;
    } pcg_osc_t;

endpackage : pcg_pkg

// ### pcg_top.sv
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// - count main ticks over sixteen slow periods
// - measurement ready only when oscillator on, valid
// - input divider: 0 none, 1 bypass, else divide
// - lock set after counter slow cycles post-write
// - multiplier zero stops pll, else times plus one
// - usb divider passes, halves or quarters pll
// - master source slow, main or pll clock
// - master prescaler divides by powers 1..64
// - each programmable clock selects its own source
// - each programmable clock has own prescaler
// - enable register sets enables, zero no effect
// - disable register clears enables, zero no effect
// - mask register reports enable state, inverted
// - status bit 0 shows oscillator stable
// - status lock bit shows pll locked
// - status shows master clock ready
// - status bits 8..11 show programmable ready
// - status, enable, disable, mask share layout
// - oscillator stable after count times eight slow
module pcg_top #(
    parameter int N_PCK  = pcg_pkg::N_PCK,
    parameter int ADDR_W = pcg_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // source clock rates as one-cycle ticks
    input  wire logic              slow_tick,
    input  wire logic              main_tick,
    input  wire logic              pll_tick,
    // generated clocks and pll control
    output logic                   pll_ref_tick,
    output logic                   pll_active,
    output logic [10:0]            pll_multiplier,
    output logic [1:0]             pll_range,
    output logic                   usb_tick,
    output logic                   mck_tick,
    output logic [N_PCK-1:0]       pck_tick,
    output logic                   irq
);

    // bus slave state
    logic                  awready_r;
    logic                  wready_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  arready_r;
    logic                  rvalid_r;
    logic [1:0]            rresp_r;
    logic [31:0]           rdata_r;
    logic                  aw_hold_r;
    logic                  w_hold_r;
    logic [ADDR_W-1:0]     aw_addr_r;
    logic [31:0]           w_data_r;
    logic [3:0]            w_strb_r;
    logic                  do_write;
    logic [7:0]            wr_off;
    logic [31:0]           wmask;
    logic [31:0]           wval;
    logic                  wr_hit;

    // block state
    pcg_pkg::pcg_osc_t     osc_r;
    pcg_pkg::pcg_pll_t     pll_r;
    pcg_pkg::pcg_clk_t     clk_cfg_r [0:N_PCK];
    logic [N_PCK:0]        clk_rdy_r;
    logic [N_PCK:0]        clk_tick_r;
    logic [N_PCK:0]        wr_clk;
    logic                  osc_stable_r;
    logic [10:0]           osc_cnt_r;
    pcg_pkg::pcg_meas_t    meas_state_r;
    logic [4:0]            meas_win_r;
    logic [15:0]           meas_cnt_r;
    logic [15:0]           main_freq_count_r;
    logic                  main_measure_valid_r;
    logic                  pll_lock_r;
    logic                  pll_pending_r;
    logic [5:0]            pll_cnt_r;
    logic [7:0]            ref_cnt_r;
    logic                  ref_tick_r;
    logic [1:0]            usb_cnt_r;
    logic                  usb_tick_r;
    logic [31:0]           ien_r;
    logic                  irq_r;
    logic [31:0]           status;
    logic [31:0]           rd_val;
    logic                  rd_hit;

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;

    // write channel: address and data taken in either order, one write at a time
    assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_off   = {aw_addr_r[7:2], 2'b00};
    assign wmask    = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign wval     = w_data_r & wmask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= pcg_pkg::REG_RST;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pcg_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready_r) begin
                aw_addr_r <= awaddr;
                aw_hold_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (wvalid && wready_r) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
                w_hold_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (do_write) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLV;
            end
            if (bvalid_r && bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // write decode; read-only registers accept and ignore writes
    always_comb begin
        wr_hit = 1'b0;
        for (int k = 0; k <= N_PCK; k++) begin
            if (wr_clk[k]) begin
                wr_hit = 1'b1;
            end
        end
        case (wr_off)
            pcg_pkg::OFF_OSC, pcg_pkg::OFF_PLL, pcg_pkg::OFF_IER, pcg_pkg::OFF_IDR,
            pcg_pkg::OFF_MCFR, pcg_pkg::OFF_SR, pcg_pkg::OFF_IMR: wr_hit = 1'b1;
            default: ;
        endcase
    end

    // main oscillator start-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_r        <= pcg_pkg::REG_RST;
            osc_stable_r <= 1'b0;
            osc_cnt_r    <= '0;
        end else if (do_write && wr_off == pcg_pkg::OFF_OSC) begin
            osc_r        <= (osc_r & ~(wmask & pcg_pkg::OSC_WMASK))
                            | (wval & pcg_pkg::OSC_WMASK);
            osc_stable_r <= wval[1];
            osc_cnt_r    <= 11'({3'b000, wval[15:8]} << pcg_pkg::OSC_SHIFT);
        end else if (osc_r.bypass) begin
            osc_stable_r <= 1'b1;
        end else if (!osc_r.enable) begin
            osc_stable_r <= 1'b0;
        end else if (!osc_stable_r && slow_tick) begin
            if (osc_cnt_r == '0) begin
                osc_stable_r <= 1'b1;
            end else begin
                osc_cnt_r <= osc_cnt_r - 11'd1;
            end
        end
    end

    // main clock measurement over one window of slow periods
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_state_r         <= pcg_pkg::MS_OFF;
            meas_win_r           <= '0;
            meas_cnt_r           <= '0;
            main_freq_count_r    <= '0;
            main_measure_valid_r <= 1'b0;
        end else if (!osc_stable_r) begin
            meas_state_r         <= pcg_pkg::MS_OFF;
            main_measure_valid_r <= 1'b0;
        end else begin
            case (meas_state_r)
                pcg_pkg::MS_OFF: begin
                    // align the window to a slow clock edge
                    if (slow_tick) begin
                        meas_state_r <= pcg_pkg::MS_COUNT;
                        meas_win_r   <= '0;
                        meas_cnt_r   <= '0;
                    end
                end
                pcg_pkg::MS_COUNT: begin
                    if (slow_tick && meas_win_r == pcg_pkg::MEAS_LAST) begin
                        main_freq_count_r    <= meas_cnt_r + {15'd0, main_tick};
                        main_measure_valid_r <= 1'b1;
                        meas_state_r         <= pcg_pkg::MS_DONE;
                    end else begin
                        meas_cnt_r <= meas_cnt_r + {15'd0, main_tick};
                        if (slow_tick) begin
                            meas_win_r <= meas_win_r + 5'd1;
                        end
                    end
                end
                pcg_pkg::MS_DONE: ;
                default: meas_state_r <= pcg_pkg::MS_OFF;
            endcase
        end
    end

    // pll configuration and lock delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_r         <= pcg_pkg::REG_RST;
            pll_lock_r    <= 1'b0;
            pll_pending_r <= 1'b0;
            pll_cnt_r     <= '0;
        end else if (do_write && wr_off == pcg_pkg::OFF_PLL) begin
            // range encodings 01 and 11 are stored as written; software avoids them
            pll_r         <= (pll_r & ~(wmask & pcg_pkg::PLL_WMASK))
                             | (wval & pcg_pkg::PLL_WMASK);
            pll_lock_r    <= 1'b0;
            pll_pending_r <= 1'b1;
            pll_cnt_r     <= w_strb_r[1] ? wval[13:8] : pll_r.lock_delay;
        end else if (pll_pending_r && slow_tick) begin
            if (pll_cnt_r == '0) begin
                pll_pending_r <= 1'b0;
                pll_lock_r    <= (pll_r.mul != '0) && (pll_r.div != '0);
            end else begin
                pll_cnt_r <= pll_cnt_r - 6'd1;
            end
        end
    end

    // pll reference divider on main clock ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_cnt_r  <= '0;
            ref_tick_r <= 1'b0;
        end else if (!osc_stable_r || pll_r.div == '0) begin
            ref_cnt_r  <= '0;
            ref_tick_r <= 1'b0;
        end else if (main_tick) begin
            ref_cnt_r  <= (ref_cnt_r >= pll_r.div - 8'd1) ? 8'd0 : ref_cnt_r + 8'd1;
            ref_tick_r <= (ref_cnt_r >= pll_r.div - 8'd1);
        end else begin
            ref_tick_r <= 1'b0;
        end
    end

    // pll control outputs; the analog loop itself lies outside
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_active     <= 1'b0;
            pll_multiplier <= '0;
            pll_range      <= '0;
        end else begin
            pll_active     <= (pll_r.mul != '0);
            pll_multiplier <= pll_r.mul;
            pll_range      <= pll_r.range;
        end
    end

    // usb divider on pll ticks; reserved encoding gives no output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_cnt_r  <= '0;
            usb_tick_r <= 1'b0;
        end else if (!pll_lock_r) begin
            usb_cnt_r  <= '0;
            usb_tick_r <= 1'b0;
        end else if (pll_tick) begin
            usb_cnt_r <= usb_cnt_r + 2'd1;
            case (pll_r.usb_clock_divider)
                pcg_pkg::USB_DIV1: usb_tick_r <= 1'b1;
                pcg_pkg::USB_DIV2: usb_tick_r <= usb_cnt_r[0];
                pcg_pkg::USB_DIV4: usb_tick_r <= &usb_cnt_r;
                default:           usb_tick_r <= 1'b0;
            endcase
        end else begin
            usb_tick_r <= 1'b0;
        end
    end

    assign pll_ref_tick = ref_tick_r;
    assign usb_tick     = usb_tick_r;

    // channel 0 is the master clock, channels 1..N_PCK the programmable clocks
    generate
        for (genvar i = 0; i <= N_PCK; i++) begin : g_clk
            localparam logic [7:0] CH_OFF = (i == 0) ? pcg_pkg::OFF_MCK
                : 8'(pcg_pkg::OFF_PCK0 + 8'(i - 1) * pcg_pkg::OFF_STEP);
            localparam logic       RDY_RST = (i == 0);
            logic [5:0] pre_cnt_r;
            logic [5:0] pre_mask;
            logic       src_tick;
            logic       src_ok;

            assign wr_clk[i] = do_write && wr_off == CH_OFF;
            assign pre_mask  = 6'((7'd1 << clk_cfg_r[i].clock_prescaler) - 7'd1);

            always_comb begin
                case (clk_cfg_r[i].css)
                    pcg_pkg::CSS_SLOW: begin
                        src_tick = slow_tick;
                        src_ok   = 1'b1;
                    end
                    pcg_pkg::CSS_MAIN: begin
                        src_tick = main_tick;
                        src_ok   = osc_stable_r;
                    end
                    pcg_pkg::CSS_PLL: begin
                        src_tick = pll_tick;
                        src_ok   = pll_lock_r;
                    end
                    default: begin
                        src_tick = 1'b0;
                        src_ok   = 1'b0;
                    end
                endcase
            end

            // ready is dropped by a write and rises on the first output edge of the new setting
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    clk_cfg_r[i]  <= pcg_pkg::REG_RST;
                    pre_cnt_r     <= '0;
                    clk_tick_r[i] <= 1'b0;
                    clk_rdy_r[i]  <= RDY_RST;
                end else if (wr_clk[i]) begin
                    clk_cfg_r[i]  <= (clk_cfg_r[i] & ~(wmask & pcg_pkg::CLK_WMASK))
                                     | (wval & pcg_pkg::CLK_WMASK);
                    pre_cnt_r     <= '0;
                    clk_tick_r[i] <= 1'b0;
                    clk_rdy_r[i]  <= 1'b0;
                end else if (!src_ok || clk_cfg_r[i].clock_prescaler == pcg_pkg::CLOCK_PRESCALER_RSVD) begin
                    pre_cnt_r     <= '0;
                    clk_tick_r[i] <= 1'b0;
                    clk_rdy_r[i]  <= 1'b0;
                end else if (src_tick) begin
                    pre_cnt_r     <= pre_cnt_r + 6'd1;
                    clk_tick_r[i] <= (pre_cnt_r & pre_mask) == pre_mask;
                    if ((pre_cnt_r & pre_mask) == pre_mask) begin
                        clk_rdy_r[i] <= 1'b1;
                    end
                end else begin
                    clk_tick_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign mck_tick = clk_tick_r[0];
    assign pck_tick = clk_tick_r[N_PCK:1];

    // status vector in the common layout
    always_comb begin
        status                           = '0;
        status[pcg_pkg::ST_OSC]          = osc_stable_r;
        status[pcg_pkg::ST_LOCK]         = pll_lock_r;
        status[pcg_pkg::ST_MCK]          = clk_rdy_r[0];
        status[pcg_pkg::ST_PCK0 +: N_PCK] = clk_rdy_r[N_PCK:1];
    end

    // interrupt enables: set and clear registers, zero bits leave state alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_r <= pcg_pkg::REG_RST;
        end else if (do_write && wr_off == pcg_pkg::OFF_IER) begin
            ien_r <= ien_r | (wval & pcg_pkg::IRQ_BITS);
        end else if (do_write && wr_off == pcg_pkg::OFF_IDR) begin
            ien_r <= ien_r & ~(wval & pcg_pkg::IRQ_BITS);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status & ien_r);
        end
    end

    assign irq = irq_r;

    // read decode; write-only registers read as zero
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case ({araddr[7:2], 2'b00})
            pcg_pkg::OFF_OSC:  rd_val = osc_r;
            pcg_pkg::OFF_MCFR: rd_val = {15'd0, main_measure_valid_r, main_freq_count_r};
            pcg_pkg::OFF_PLL:  rd_val = pll_r;
            pcg_pkg::OFF_IER:  rd_val = '0;
            pcg_pkg::OFF_IDR:  rd_val = '0;
            pcg_pkg::OFF_SR:   rd_val = status;
            pcg_pkg::OFF_IMR:  rd_val = ~ien_r & pcg_pkg::IRQ_BITS;
            default:           rd_hit = 1'b0;
        endcase
        for (int k = 0; k <= N_PCK; k++) begin
            if ({araddr[7:2], 2'b00} == ((k == 0) ? pcg_pkg::OFF_MCK
                    : 8'(pcg_pkg::OFF_PCK0 + 8'(k - 1) * pcg_pkg::OFF_STEP))) begin
                rd_val = clk_cfg_r[k];
                rd_hit = 1'b1;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= pcg_pkg::RESP_OKAY;
            rdata_r   <= pcg_pkg::REG_RST;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_val;
            rresp_r   <= rd_hit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLV;
        end else if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

endmodule : pcg_top

// ### pcg_chk.sv
`timescale 1ns/1ps
module pcg_chk #(
    parameter int N_PCK = 4
) (
    // clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // bus handshakes
    input wire logic             awready,
    input wire logic             wready,
    input wire logic             bvalid,
    input wire logic             bready,
    input wire logic             arvalid,
    input wire logic             arready,
    input wire logic             rvalid,
    input wire logic             rready,
    input wire logic [31:0]      rdata,
    // source and output ticks
    input wire logic             slow_tick,
    input wire logic             main_tick,
    input wire logic             pll_tick,
    input wire logic             pll_ref_tick,
    input wire logic             usb_tick,
    input wire logic             mck_tick,
    input wire logic             pll_active,
    input wire logic [N_PCK-1:0] pck_tick,
    input wire logic [10:0]      pll_multiplier
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    a_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_w_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_pll_act: assert property (pll_active == (pll_multiplier != 11'h000))
        else $error("pll active disagrees with multiplier");
    a_ref_src: assert property (pll_ref_tick |-> $past(main_tick))
        else $error("reference tick without main tick");
    a_usb_src: assert property (usb_tick |-> $past(pll_tick) && pll_active)
        else $error("usb tick without pll tick");
    a_mck_src: assert property (mck_tick |-> $past(slow_tick | main_tick | pll_tick))
        else $error("master tick without source tick");
    a_pck_src: assert property (|pck_tick |-> $past(slow_tick | main_tick | pll_tick))
        else $error("programmable tick without source tick");
    c_usb: cover property (usb_tick);
    c_wr: cover property (bvalid && bready);
    c_rd: cover property (rvalid && rready);
endmodule : pcg_chk

// ### test_pmc_clock_gen_and_select.sv
`timescale 1ns/1ps
module test_pmc_clock_gen_and_select;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, slow_tick = 0, main_tick = 0, pll_tick = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [3:0]  wstrb = 4'hf, pck_tick;
    logic [1:0]  bresp, rresp, pll_range, rsp;
    logic [10:0] pll_multiplier;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        pll_ref_tick, pll_active, usb_tick, mck_tick, irq;
    int          failures = 0, checks_done = 0, cyc = 0;
    int          n [7];
    logic [7:0]  mc [6] = '{8'h00, 8'h04, 8'h09, 8'h03, 8'h02, 8'h1c};
    int          em [6] = '{12, 6, 12, 32, 0, 0};
    logic [7:0]  pc [4] = '{8'h01, 8'h05, 8'h03, 8'h02};
    pcg_top dut (.*);
    initial forever #12.5 aclk = ~aclk;
    // sources: slow every 8, main every 2, pll every 3 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        slow_tick <= (cyc % 8 == 7);
        main_tick <= (cyc % 2 == 1);
        pll_tick <= (cyc % 3 == 0);
    end
    task chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task end_sim;
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bready && bvalid) begin
                bready <= 0;
                rsp = bresp;
            end
        end while (awvalid | wvalid | bready);
    endtask : wr
    task rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rready && rvalid) begin
                rready <= 0;
                got = rdata;
                rsp = rresp;
            end
        end while (arvalid | rready);
    endtask : rd
    // tick counts over 96 cycles; phase slop allows one either way
    task meas;
        n = '{default: 0};
        repeat (96) begin
            @(posedge aclk);
            n[0] += mck_tick; n[1] += usb_tick; n[2] += pll_ref_tick;
            for (int i = 0; i < 4; i++) n[3+i] += pck_tick[i];
        end
    endtask : meas
    task cn(input int k, input int e);
        chk((n[k] + 1 >= e) && (n[k] <= e + 1), 1);
    endtask : cn
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0008);
        rd(pcg_pkg::OFF_IMR); chk(got, 32'h0000_0f0d);
        rd(pcg_pkg::OFF_MCFR); chk(got, 0);
        wr(pcg_pkg::OFF_IER, 32'h0000_0008); wr(pcg_pkg::OFF_IDR, 0);
        rd(pcg_pkg::OFF_IMR); chk(got, 32'h0000_0f05);
        chk(irq, 1);
        wr(pcg_pkg::OFF_IER, 0); wr(pcg_pkg::OFF_IDR, 32'h0000_0008);
        rd(pcg_pkg::OFF_IMR); chk(got, 32'h0000_0f0d);
        chk(irq, 0);
        rd(8'h10); chk({rsp, got}, {pcg_pkg::RESP_SLV, 32'h0000_0000});
        wr(8'h10, 1); chk(rsp, pcg_pkg::RESP_SLV);
        // programmable clocks reset onto the slow clock, so they are ready after its first edge
        wr(pcg_pkg::OFF_OSC, 32'h0000_0002);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0f09);
        wr(pcg_pkg::OFF_OSC, 32'h0000_0101);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0f08);
        repeat (50) @(posedge aclk);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0f08);
        repeat (32) @(posedge aclk);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0f09);
        repeat (160) @(posedge aclk);
        rd(pcg_pkg::OFF_MCFR); chk(got[16], 1);
        chk(got[15:0] >= 63 && got[15:0] <= 65, 1);
        wr(pcg_pkg::OFF_PLL, 32'h1001_8201);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0f09);
        chk({pll_active, pll_range, pll_multiplier}, {1'b1, 2'h2, 11'h001});
        repeat (40) @(posedge aclk);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_0f0d);
        rd(pcg_pkg::OFF_PLL); chk(got, 32'h1001_8201);
        meas; cn(1, 16);
        cn(2, 48);
        for (int i = 0; i < 6; i++) begin
            wr(pcg_pkg::OFF_MCK, 32'(mc[i]));
            repeat (16) @(posedge aclk);
            meas; cn(0, em[i]);
            rd(pcg_pkg::OFF_SR); chk(got[3], em[i] != 0);
        end
        wr(pcg_pkg::OFF_MCK, 0);
        for (int i = 0; i < 4; i++) wr(pcg_pkg::OFF_PCK0 + 8'(4 * i), 32'(pc[i]));
        meas; cn(3, 48); cn(4, 24); cn(5, 32); cn(6, 0);
        rd(pcg_pkg::OFF_SR); chk(got, 32'h0000_070d);
        wr(pcg_pkg::OFF_PLL, 0); chk(pll_active, 0);
        meas; cn(1, 0);
        rd(pcg_pkg::OFF_SR); chk(got[2], 0);
        end_sim;
    end
    // whole run is near 1500 cycles, so this only trips on a hang
    initial begin
        #150us;
        failures++;
        end_sim;
    end
endmodule : test_pmc_clock_gen_and_select
bind pcg_top pcg_chk #(.N_PCK(N_PCK)) u_chk (.*);
